// [sim/power_digital_signal_router_tb.sv]
/* testbench for the power digital signal router: apb driver, routing
   expectations and a monitor that pops the oldest expected note.
   assumes the far-side model changes sources on every rising edge. */
`timescale 1ns/1ps
`default_nettype none
module power_digital_signal_router_tb;
    import router_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  mod_o;
    logic [5:0]  cmp_o;
    logic [3:0]  pin_i;
    logic [3:0]  dim_o;
    logic [3:0]  flt_o;
    logic [3:0]  pin_o;
    logic [7:0]  regs [6];
    logic [32:0] q [$];
    logic [32:0] e;
    logic [32:0] r;
    logic [31:0] d;
    int          num_errors = 0;
    int          checked = 0;
    event        look;
    // pin code to source number; 15 is the tied-low slot
    localparam logic [63:0] PTAB [4] = '{64'hFFFFFF98F6543210,
        64'hFFFFFFF97FFFF321, 64'hFFFFFFFFF6541032, 64'hFFFFFFF86F542103};
    power_digital_signal_router dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modulator_output(mod_o),
        .bank_comparator_output(cmp_o), .function_pin_in(pin_i),
        .dimming_input(dim_o), .fault_input(flt_o),
        .function_pin_port(pin_o));
    source_far_model far (.pclk(pclk), .modulator_output(mod_o),
        .bank_comparator_output(cmp_o), .function_pin_in(pin_i));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    function automatic logic [7:0] ad(input int i);
        return {IDX_FIRST + 6'(i), 2'h0};
    endfunction : ad
    function automatic logic [11:0] route();
        logic [15:0] s;
        logic [3:0]  dc;
        logic [3:0]  t;
        logic [3:0]  p;
        logic [11:0] y;
        s = {6'h0, mod_o, cmp_o};
        for (int n = 0; n < 4; n++) begin
            dc = 4'((regs[n / 2] >> (3 * (n % 2))) & 8'h07);
            t = 4'(regs[2 + n / 2] >> (4 * (n % 2)));
            p = 4'(regs[4 + n / 2] >> (4 * (n % 2)));
            y[n] = dc < 4 ? mod_o[2'(dc + n)] : pin_i[2'(dc - 4)];
            y[4 + n] = t < 4 ? cmp_o[2'(t + n)] : t < 6 ? cmp_o[t]
                     : t < 10 ? pin_i[2'(t - 6)] : 1'b0;
            y[8 + n] = s[PTAB[n][4 * p +: 4]];
        end
        return y;
    endfunction : route
    task automatic check(input string nm, input logic [32:0] s,
                         input logic [32:0] x);
        checked++;
        if (s !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] dw, input logic [32:0] ex);
        int n;
        n = 0;
        q.push_back(ex);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic chk();
        @(negedge pclk);
        q.push_back({21'h0, route()});
        -> look;
        @(posedge pclk);
    endtask : chk
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = q.pop_front();
            check("apb", {pslverr, pwrite ? 32'h0 : prdata}, e);
        end
    end
    always @(look) begin
        r = q.pop_front();
        check("dim", 33'(dim_o), 33'(r[3:0]));
        check("trip", 33'(flt_o), 33'(r[7:4]));
        check("pin0", 33'(pin_o[0]), 33'(r[8]));
        check("pin1", 33'(pin_o[1]), 33'(r[9]));
        check("pin2", 33'(pin_o[2]), 33'(r[10]));
        check("pin3", 33'(pin_o[3]), 33'(r[11]));
    end
    initial begin
        void'($urandom(32'hEAB9CB21));
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            regs[i] = 8'h00;
            xfer(1'b0, ad(i), 32'h0, 33'h0);
        end
        chk();
        for (int i = 0; i < 6; i++) begin
            d = $urandom & (i < 2 ? 32'h3F : 32'hFF);
            xfer(1'b1, ad(i), d, 33'h0);
            xfer(1'b0, ad(i), 32'h0, {1'b0, d});
            regs[i] = d[7:0];
        end
        chk();
        xfer(1'b1, 8'h61, 32'hFF, {1'b1, 32'h0});
        xfer(1'b0, 8'h7C, 32'h0, {1'b1, 32'h0});
        // status word is read-only, a write is refused
        xfer(1'b1, 8'h78, 32'h0, {1'b1, 32'h0});
        xfer(1'b0, ad(0), 32'h0, {25'h0, regs[0]});
        for (int c = 0; c < 16; c++) begin
            for (int i = 0; i < 6; i++) begin
                d = i < 2 ? {26'h0, 3'(c + 5), 3'(c)}
                          : {24'h0, 4'(c + 7), 4'(c)};
                regs[i] = d[7:0];
                xfer(1'b1, ad(i), d, 33'h0);
            end
            repeat (3) chk();
        end
        // a second reset in mid-run clears every select
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            regs[i] = 8'h00;
            xfer(1'b0, ad(i), 32'h0, 33'h0);
        end
        chk();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        conclude();
    end
endmodule : power_digital_signal_router_tb
bind power_digital_signal_router router_checker chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modulator_output(modulator_output),
    .bank_comparator_output(bank_comparator_output),
    .function_pin_in(function_pin_in), .dimming_input(dimming_input),
    .fault_input(fault_input), .function_pin_port(function_pin_port));
`default_nettype wire

// [sim/router_checker.sv]
/* checker: apb timing and lane routing of the router top, judged
   against a shadow of the select registers.
   assumes it is bound to the top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module router_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  modulator_output,
    input wire logic [5:0]  bank_comparator_output,
    input wire logic [3:0]  function_pin_in,
    input wire logic [3:0]  dimming_input,
    input wire logic [3:0]  fault_input,
    input wire logic [3:0]  function_pin_port
);
    import router_pkg::*;
    logic [7:0] sh_q [6];
    logic       wr_ok;
    // refused writes must not move the shadow
    assign wr_ok = psel && penable && pready && pwrite && !pslverr
                   && paddr[7:5] == 3'h3 && paddr[4:2] < 3'h6
                   && paddr[1:0] == 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= '{default: 8'h00};
        end else if (wr_ok) begin
            sh_q[paddr[4:2]] <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_setup_answered: assert property (psel && !penable |=> pready)
        else $error("setup not answered next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_dim0_modulator: assert property (!sh_q[0][2]
        |-> dimming_input[0] == modulator_output[sh_q[0][1:0]])
        else $error("channel 0 dimming route wrong");
    a_dim1_pin: assert property (sh_q[0][5]
        |-> dimming_input[1] == function_pin_in[sh_q[0][4:3]])
        else $error("channel 1 dimming route wrong");
    a_dim3_rotated: assert property (!sh_q[1][5]
        |-> dimming_input[3] == modulator_output[2'(sh_q[1][4:3] + 2'h3)])
        else $error("channel 3 dimming route wrong");
    a_trip_grounded: assert property (sh_q[2][3:0] > 4'h9
        |-> !fault_input[0])
        else $error("grounded fault input not low");
    a_trip3_last_cmp: assert property (sh_q[3][7:4] == 4'h5
        |-> fault_input[3] == bank_comparator_output[5])
        else $error("channel 3 fault route wrong");
    a_pin0_low: assert property (sh_q[4][3:0] > 4'hD
        |-> !function_pin_port[0])
        else $error("pin 0 not low");
    a_pin2_mod0: assert property (sh_q[5][3:0] == 4'h6
        |-> function_pin_port[2] == modulator_output[0])
        else $error("pin 2 modulator route wrong");
    c_refused: cover property (pslverr);
    c_grounded: cover property (sh_q[2][3:0] > 4'h9);
    c_read: cover property (pready && !pwrite);
endmodule : router_checker
`default_nettype wire

// [sim/source_far_model.sv]
/* far side: modulators, comparator bank and function pin levels.
   assumes one pclk domain; a fresh pattern lands every cycle. */
`timescale 1ns/1ps
`default_nettype none
module source_far_model (
    input  wire logic       pclk,
    output logic      [3:0] modulator_output,
    output logic      [5:0] bank_comparator_output,
    output logic      [3:0] function_pin_in
);
    // new pattern each cycle so a stuck route cannot match by luck
    initial begin
        {modulator_output, bank_comparator_output, function_pin_in} = 14'h0;
        forever begin
            @(posedge pclk);
            {modulator_output, bank_comparator_output, function_pin_in} <=
                14'($urandom);
        end
    end
endmodule : source_far_model
`default_nettype wire

// [verilog/lane_if.sv]
/*
 * carrier for one routing lane: the shared source vector, the chosen
 * source number and the routed bit.
 * assumes the router top drives src and idx and a lane drives y.
 */
`timescale 1ns/1ps
`default_nettype none

interface lane_if;
    logic [15:0] src;
    logic [3:0]  idx;
    logic        y;

    modport lane (input src, input idx, output y);
    modport top  (output src, output idx, input y);
endinterface : lane_if

`default_nettype wire

// [verilog/power_digital_signal_router.sv]
/*
 * power digital signal router: six select registers behind an apb slave
 * steer modulator, comparator and function pin signals onto the dimming
 * and fault inputs of four controller channels and onto four pins.
 * assumes a single pclk domain and sources already on this clock or
 * tolerant of a purely combinational path.
 */
// Contract
// - channel 0 dim: codes 0-3 modulators 0..3, 4-7 pins 0..3
// - channel 1 dim: codes 0-3 modulators 1,2,3,0, 4-7 pins 0..3
// - channel 2 dim: codes 0-3 modulators 2,3,0,1, 4-7 pins 0..3
// - channel 3 dim: codes 0-3 modulators 3,0,1,2, 4-7 pins 0..3
// - channel 0 trip: codes 0-5 comparators 8..13, 6-9 pins 0..3
// - channel 1 trip: comparators 9,10,11,8,12,13, then pins 0..3
// - channel 2 trip: comparators 10,11,8,9,12,13, then pins 0..3
// - channel 3 trip: comparators 11,8,9,10,12,13, then pins 0..3
// - trip codes 10 to 15 hold the fault input low
// - pin 0: comparators 8..13, then modulators 0, 2, 3 at 6, 8, 9
// - pin 0 codes 14 and 15 drive low
// - pin 1: comparators 9,10,11, modulator 1 at 7, code 15 low
// - pin 2: comparators 10,11,8,9,12,13, modulator 0 at 6, 15 low
// - pin 3: comparators 11,8,9,10,12,13, codes 14 and 15 low
`timescale 1ns/1ps
`default_nettype none

module power_digital_signal_router (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [router_pkg::ADDR_W-1:0] paddr,
    input  wire logic [router_pkg::DATA_W-1:0] pwdata,
    output logic      [router_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [router_pkg::NUM_MOD-1:0] modulator_output,
    input  wire logic [router_pkg::NUM_CMP-1:0] bank_comparator_output,
    input  wire logic [router_pkg::NUM_PIN-1:0] function_pin_in,
    output logic      [router_pkg::NUM_CH-1:0]  dimming_input,
    output logic      [router_pkg::NUM_CH-1:0]  fault_input,
    output logic      [router_pkg::NUM_PIN-1:0] function_pin_port
);
    import router_pkg::*;

    typedef struct packed {
        logic [NUM_SEL-1:0][REG_W-1:0] sel;
        logic [DATA_W-1:0]             rdata;
        logic                          ready;
        logic                          err;
        logic [ST_W-1:0]               status;
    } state_t;

    state_t q;
    state_t d;

    logic [SRC_W-1:0]            src_vec;
    logic [NUM_LANE-1:0][3:0]    lane_idx;
    logic [NUM_LANE-1:0]         lane_y;
    logic [5:0]                  word_idx;
    logic                        aligned;
    logic                        hit_sel;
    logic                        hit_status;
    logic [2:0]                  slot;

    // channel dim: pins by code bit 2, else modulator rotated by channel
    function automatic logic [3:0] dim_src(input logic [1:0] ch,
                                           input logic [2:0] code);
        logic [1:0] m;
        m = 2'(code[1:0] + ch);
        if (code[2]) begin
            dim_src = 4'(SRC_PIN0 + 4'(code[1:0]));
        end else begin
            dim_src = 4'(SRC_MOD0 + 4'(m));
        end
    endfunction : dim_src

    // channel trip: first four comparators rotate, 12 and 13 fixed
    function automatic logic [3:0] trip_src(input logic [1:0] ch,
                                            input logic [3:0] code);
        logic [1:0] c;
        c = 2'(code[1:0] + ch);
        trip_src = SRC_GND;
        if (code <= 4'h3) begin
            trip_src = 4'(SRC_CMP8 + 4'(c));
        end else if (code <= 4'h5) begin
            trip_src = code;
        end else if (code <= 4'h9) begin
            trip_src = 4'(SRC_PIN0 + 4'(code - 4'h6));
        end
    endfunction : trip_src

    // pin 0 table; code 7 is printed twice, so it stays low
    function automatic logic [3:0] pin0_src(input logic [3:0] code);
        pin0_src = SRC_GND;
        unique case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
                pin0_src = code;
            end
            4'h6: begin
                pin0_src = SRC_MOD0;
            end
            4'h8: begin
                pin0_src = SRC_MOD2;
            end
            4'h9: begin
                pin0_src = SRC_MOD3;
            end
            default: begin
                pin0_src = SRC_GND;
            end
        endcase
    endfunction : pin0_src

    // pin 1 table; clashing codes 3 to 6 stay low
    function automatic logic [3:0] pin1_src(input logic [3:0] code);
        pin1_src = SRC_GND;
        unique case (code)
            4'h0: begin
                pin1_src = SRC_CMP9;
            end
            4'h1: begin
                pin1_src = SRC_CMP10;
            end
            4'h2: begin
                pin1_src = SRC_CMP11;
            end
            4'h7: begin
                pin1_src = SRC_MOD1;
            end
            4'h8: begin
                pin1_src = SRC_MOD3;
            end
            default: begin
                pin1_src = SRC_GND;
            end
        endcase
    endfunction : pin1_src

    // pin 2 table; code 8 names three sources, so it stays low
    function automatic logic [3:0] pin2_src(input logic [3:0] code);
        pin2_src = SRC_GND;
        unique case (code)
            4'h0: begin
                pin2_src = SRC_CMP10;
            end
            4'h1: begin
                pin2_src = SRC_CMP11;
            end
            4'h2: begin
                pin2_src = SRC_CMP8;
            end
            4'h3: begin
                pin2_src = SRC_CMP9;
            end
            4'h4: begin
                pin2_src = SRC_CMP12;
            end
            4'h5: begin
                pin2_src = SRC_CMP13;
            end
            4'h6: begin
                pin2_src = SRC_MOD0;
            end
            default: begin
                pin2_src = SRC_GND;
            end
        endcase
    endfunction : pin2_src

    // pin 3 table; only unambiguous modulator codes are kept
    function automatic logic [3:0] pin3_src(input logic [3:0] code);
        pin3_src = SRC_GND;
        unique case (code)
            4'h0: begin
                pin3_src = SRC_CMP11;
            end
            4'h1: begin
                pin3_src = SRC_CMP8;
            end
            4'h2: begin
                pin3_src = SRC_CMP9;
            end
            4'h3: begin
                pin3_src = SRC_CMP10;
            end
            4'h4: begin
                pin3_src = SRC_CMP12;
            end
            4'h5: begin
                pin3_src = SRC_CMP13;
            end
            4'h7: begin
                pin3_src = SRC_MOD0;
            end
            4'h8: begin
                pin3_src = SRC_MOD2;
            end
            default: begin
                pin3_src = SRC_GND;
            end
        endcase
    endfunction : pin3_src

    assign src_vec = {2'b00, function_pin_in, modulator_output,
                      bank_comparator_output};

    always_comb begin
        lane_idx[0] = dim_src(2'd0, q.sel[SLOT_DIM01][DIM_LO_POS +: 3]);
        lane_idx[1] = dim_src(2'd1, q.sel[SLOT_DIM01][DIM_HI_POS +: 3]);
        lane_idx[2] = dim_src(2'd2, q.sel[SLOT_DIM23][DIM_LO_POS +: 3]);
        lane_idx[3] = dim_src(2'd3, q.sel[SLOT_DIM23][DIM_HI_POS +: 3]);
        lane_idx[4] = trip_src(2'd0, q.sel[SLOT_TRIP01][NIB_LO_POS +: 4]);
        lane_idx[5] = trip_src(2'd1, q.sel[SLOT_TRIP01][NIB_HI_POS +: 4]);
        lane_idx[6] = trip_src(2'd2, q.sel[SLOT_TRIP23][NIB_LO_POS +: 4]);
        lane_idx[7] = trip_src(2'd3, q.sel[SLOT_TRIP23][NIB_HI_POS +: 4]);
        lane_idx[8] = pin0_src(q.sel[SLOT_PIN01][NIB_LO_POS +: 4]);
        lane_idx[9] = pin1_src(q.sel[SLOT_PIN01][NIB_HI_POS +: 4]);
        lane_idx[10] = pin2_src(q.sel[SLOT_PIN23][NIB_LO_POS +: 4]);
        lane_idx[11] = pin3_src(q.sel[SLOT_PIN23][NIB_HI_POS +: 4]);
    end

    // one gate-only lane per routed output
    for (genvar i = 0; i < NUM_LANE; i++) begin : g_lane
        lane_if u_if ();
        assign u_if.src  = src_vec;
        assign u_if.idx  = lane_idx[i];
        assign lane_y[i] = u_if.y;
        source_lane u_lane (
            .port (u_if.lane)
        );
    end

    // routed outputs bypass the flops on purpose: a trip must not wait
    assign dimming_input     = lane_y[3:0];
    assign fault_input       = lane_y[7:4];
    assign function_pin_port = lane_y[11:8];

    assign word_idx   = paddr[7:2];
    assign aligned    = (paddr[1:0] == 2'b00);
    assign hit_sel    = aligned && (word_idx >= IDX_FIRST)
                        && (word_idx < IDX_ROUTE_STATUS);
    assign hit_status = aligned && (word_idx == IDX_ROUTE_STATUS);
    assign slot       = 3'(word_idx - IDX_FIRST);

    always_comb begin
        d        = q;
        d.status = {lane_y[11:8], lane_y[7:4], lane_y[3:0]};
        d.ready  = 1'b0;
        d.err    = 1'b0;
        // setup phase: answer is ready in the first access cycle
        if (psel && !penable) begin
            d.ready = 1'b1;
            d.rdata = '0;
            if (hit_sel && !pwrite) begin
                d.rdata = DATA_W'(q.sel[slot]);
            end else if (hit_status && !pwrite) begin
                d.rdata = DATA_W'(q.status);
            end else if (!hit_sel) begin
                d.err = 1'b1;
            end
        end
        // write lands at the edge that completes the access phase
        if (psel && penable && q.ready && pwrite && hit_sel) begin
            // reserved dim bits kept zero regardless of software
            if (slot == 3'(SLOT_DIM01) || slot == 3'(SLOT_DIM23)) begin
                d.sel[slot] = pwdata[REG_W-1:0] & DIM_MASK;
            end else begin
                d.sel[slot] = pwdata[REG_W-1:0] & FULL_MASK;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.sel    <= {NUM_SEL{SEL_RESET}};
            q.rdata  <= '0;
            q.ready  <= 1'b0;
            q.err    <= 1'b0;
            q.status <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata  = q.rdata;
    assign pready  = q.ready;
    assign pslverr = q.err;

endmodule : power_digital_signal_router

`default_nettype wire

// [verilog/router_pkg.sv]
/*
 * constants for the power digital signal router: register indices,
 * field positions, reset values, write masks and source
 * numbering for the routing lanes.
 * assumes a 32-bit apb bus with one register per aligned word.
 */
`default_nettype none

package router_pkg;

    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned NUM_SEL  = 6;
    localparam int unsigned NUM_CH   = 4;
    localparam int unsigned NUM_CMP  = 6;
    localparam int unsigned NUM_MOD  = 4;
    localparam int unsigned NUM_PIN  = 4;
    localparam int unsigned NUM_LANE = 12;
    localparam int unsigned SRC_W    = 16;
    localparam int unsigned IDX_W    = 4;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_DIM_SELECT_CH0_CH1   = 6'h18;
    localparam logic [5:0] IDX_DIM_SELECT_CH2_CH3   = 6'h19;
    localparam logic [5:0] IDX_TRIP_SELECT_CH0_CH1  = 6'h1A;
    localparam logic [5:0] IDX_TRIP_SELECT_CH2_CH3  = 6'h1B;
    localparam logic [5:0] IDX_PIN_DRIVE_SELECT_0_1 = 6'h1C;
    localparam logic [5:0] IDX_PIN_DRIVE_SELECT_2_3 = 6'h1D;
    localparam logic [5:0] IDX_ROUTE_STATUS         = 6'h1E;
    localparam logic [5:0] IDX_FIRST                = IDX_DIM_SELECT_CH0_CH1;

    // slot of each register inside the select array
    localparam int unsigned SLOT_DIM01  = 0;
    localparam int unsigned SLOT_DIM23  = 1;
    localparam int unsigned SLOT_TRIP01 = 2;
    localparam int unsigned SLOT_TRIP23 = 3;
    localparam int unsigned SLOT_PIN01  = 4;
    localparam int unsigned SLOT_PIN23  = 5;

    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] DIM_MASK  = 8'h3F;
    localparam logic [7:0] FULL_MASK = 8'hFF;

    // field positions: dim fields are 3 bits, trip and pin fields 4 bits
    localparam int unsigned DIM_LO_POS  = 0;
    localparam int unsigned DIM_HI_POS  = 3;
    localparam int unsigned NIB_LO_POS  = 0;
    localparam int unsigned NIB_HI_POS  = 4;

    // status layout
    localparam int unsigned ST_DIM_POS   = 0;
    localparam int unsigned ST_FAULT_POS = 4;
    localparam int unsigned ST_PIN_POS   = 8;
    localparam int unsigned ST_W         = 12;

    // numbering of the shared source vector
    localparam logic [3:0] SRC_CMP8 = 4'h0;
    localparam logic [3:0] SRC_CMP9 = 4'h1;
    localparam logic [3:0] SRC_CMP10 = 4'h2;
    localparam logic [3:0] SRC_CMP11 = 4'h3;
    localparam logic [3:0] SRC_CMP12 = 4'h4;
    localparam logic [3:0] SRC_CMP13 = 4'h5;
    localparam logic [3:0] SRC_MOD0 = 4'h6;
    localparam logic [3:0] SRC_MOD1 = 4'h7;
    localparam logic [3:0] SRC_MOD2 = 4'h8;
    localparam logic [3:0] SRC_MOD3 = 4'h9;
    localparam logic [3:0] SRC_PIN0 = 4'hA;
    localparam logic [3:0] SRC_GND  = 4'hE;

endpackage : router_pkg

`default_nettype wire

// [verilog/source_lane.sv]
/*
 * one routing lane: picks a bit of the source vector by number.
 * assumes the ground slots of the source vector are tied low.
 */
`timescale 1ns/1ps
`default_nettype none

module source_lane (
    lane_if.lane port
);
    import router_pkg::*;

    // plain gate path, no storage, so the route adds no cycle
    assign port.y = port.src[port.idx];

endmodule : source_lane

`default_nettype wire
